// ---- core/csr_defs.vh ----
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// command codes of the word registers
`define CSR_CMD_CURRENT      8'h14
`define CSR_CMD_VOLTAGE      8'h15
`define CSR_CMD_STATUS       8'h20

// charge current setpoint layout (64 mA per lsb at bit 6)
`define CSR_CUR_KEEP_MASK    16'h1fc0
`define CSR_CUR_BAD_MASK     16'he000
`define CSR_CUR_RESET        16'h0000

// charge voltage setpoint layout (8 mV per lsb at bit 3)
`define CSR_VOLT_KEEP_MASK   16'h7ff8
`define CSR_VOLT_BAD_MASK    16'h8000
`define CSR_VOLT_MIN_MV      16'h0400
`define CSR_VOLT_MAX_MV      16'h4b00
`define CSR_VOLT_1CELL_MV    16'h1068
`define CSR_VOLT_2CELL_MV    16'h20d0
`define CSR_VOLT_3CELL_MV    16'h3138
`define CSR_VOLT_4CELL_MV    16'h41a0

// status word
`define CSR_STAT_RESET       16'h0000
`define CSR_STAT_RW_MASK     16'h0018
`define CSR_STAT_SYSOV_BIT   4
`define CSR_STAT_SYSUV_BIT   3

// pre-charge clamps
`define CSR_PRECHG_CLAMP_MA  16'h0180
`define CSR_LINFAST_CLAMP_MA 16'h07d0
`define CSR_1CELL_PRECHG_MV  16'h0bb8
`define CSR_1CELL_LINEAR_MV  16'h0e10

`endif

// ---- core/csr_precharge_clamp.v ----
`timescale 1ns/1ps
`include "csr_defs.vh"

module csr_precharge_clamp (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // setpoint and pack state
  input  wire [15:0] i_current_set_ma,
  input  wire        i_single_cell,
  input  wire        i_linear_precharge_enable,
  input  wire [15:0] i_vbat_mv,
  input  wire [15:0] i_vsys_min_mv,
  // regulation targets
  output reg  [15:0] o_current_target_ma,
  output reg         o_precharge_active,
  output reg         o_battery_switch_linear,
  output reg         o_sys_at_min
);

  reg        precharge;
  reg        linear;
  reg [15:0] target;

  always @* begin
    precharge = 1'b0;
    linear    = 1'b0;
    target    = i_current_set_ma;
    if (i_single_cell) begin
      precharge = (i_vbat_mv < `CSR_1CELL_PRECHG_MV); // RULE4
      linear    = i_linear_precharge_enable && (i_vbat_mv < `CSR_1CELL_LINEAR_MV); // RULE5
    end else begin
      precharge = (i_vbat_mv < i_vsys_min_mv);
      linear    = i_linear_precharge_enable && precharge;
    end
    if (i_linear_precharge_enable) begin
      if (precharge && target > `CSR_PRECHG_CLAMP_MA) begin
        target = `CSR_PRECHG_CLAMP_MA; // RULE3 RULE4
      end else if (i_single_cell && linear && !precharge && target > `CSR_LINFAST_CLAMP_MA) begin
        target = `CSR_LINFAST_CLAMP_MA; // RULE5
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_current_target_ma     <= 16'h0000;
      o_precharge_active      <= 1'b0;
      o_battery_switch_linear <= 1'b0;
      o_sys_at_min            <= 1'b0;
    end else begin
      o_current_target_ma     <= target;
      o_precharge_active      <= precharge;
      o_battery_switch_linear <= linear;
      o_sys_at_min            <= precharge && !i_single_cell && i_linear_precharge_enable; // RULE3
    end
  end

endmodule

// ---- core/csr_charge_regs.v ----
// Behaviour
// RULE1: current setpoint bit 7 adds 128 mA when set.
// RULE2: bit 6 adds 64 mA; bits 5..0 ignored and read zero.
// RULE3: multi-cell pre-charge holds system at minimum and clamps current to 384 mA; code does both only with i_linear_precharge_enable set.
// RULE4: single cell pre-charges below 3 V with current clamped to 384 mA; code clamps only with i_linear_precharge_enable set.
// RULE5: single cell stays linear below 3.6 V; fast current clamped to 2 A; code does both only with i_linear_precharge_enable set.
// RULE6: voltage setpoint accepted from 1.024 V to 19.200 V in 8 mV steps.
// RULE7: voltage writes outside that range are discarded.
// RULE8: reset loads voltage default from cell count: 4.2/8.4/12.6/16.8 V.
// RULE9: with input power good, a current write starts charge at current voltage.
// RULE10: host writes voltage before current when cells differ from 4.2 V.
// RULE11: writing zero voltage keeps voltage and clears current, stopping charge.
// RULE12: voltage bits 14..3 weigh 16384 mV down to 8 mV; bits 2..0 ignored.
// RULE13: voltage write with bit 15 set is invalid.
// RULE14: status high byte reports eight read-only conditions, reset 0000h.
// RULE15: status low byte reports faults; bits 4 and 3 writable.
// RULE16: current bits 12..8 weigh 4096..256 mA; bits 15..13 set is invalid.
// RULE17: current clears on removal, register reset, zero voltage, watchdog expiry.
// RULE18: an invalid write leaves the whole register unchanged.
`timescale 1ns/1ps
`include "csr_defs.vh"

module csr_charge_regs (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // host word access (decoded word transactions)
  input  wire        i_wr_stb,
  input  wire        i_rd_stb,
  input  wire [7:0]  i_cmd,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_rdata,
  output reg         o_rd_valid,
  // pack and input pins
  input  wire [1:0]  i_cell_count_presence_pin,
  input  wire        i_battery_present,
  input  wire        i_input_power_good,
  input  wire        i_register_reset,
  input  wire        i_watchdog_expired,
  input  wire        i_linear_precharge_enable,
  input  wire [15:0] i_vbat_mv,
  input  wire [15:0] i_vsys_min_mv,
  // status conditions
  input  wire        i_input_present_flag,
  input  wire        i_current_optimizer_complete,
  input  wire        i_peak_assist_active,
  input  wire        i_input_voltage_regulating,
  input  wire        i_input_current_regulating,
  input  wire        i_fast_charge_active,
  input  wire        i_reverse_output_active,
  input  wire        i_input_overvoltage_fault,
  input  wire        i_battery_overcurrent_fault,
  input  wire        i_input_overcurrent_fault,
  input  wire        i_system_overvoltage_fault,
  input  wire        i_system_undervoltage_fault,
  input  wire        i_converter_off_fault,
  input  wire        i_reverse_output_overvoltage_fault,
  input  wire        i_reverse_output_undervoltage_fault,
  // setpoints and regulation targets
  output reg  [15:0] o_charge_current_ma,
  output reg  [15:0] o_charge_voltage_mv,
  output reg         o_charge_enable,
  output wire [15:0] o_current_target_ma,
  output wire        o_precharge_active,
  output wire        o_battery_switch_linear,
  output wire        o_sys_at_min
);

  reg  [15:0] status_q;
  reg  [15:0] status_d;
  reg  [15:0] cur_d;
  reg  [15:0] volt_d;
  reg  [15:0] rdata_d;
  wire [15:0] volt_masked;
  wire        wr_cur;
  wire        wr_volt;
  wire        wr_stat;
  wire        cur_bad;
  wire        volt_bad;
  wire        volt_zero;
  wire        volt_in_range;
  wire        cur_clear_evt;
  wire        single_cell;

  // default charge voltage for the strapped cell count
  function [15:0] csr_cell_default;
    input [1:0] cells;
    begin
      case (cells)
        2'h0:    csr_cell_default = `CSR_VOLT_1CELL_MV;
        2'h1:    csr_cell_default = `CSR_VOLT_2CELL_MV;
        2'h2:    csr_cell_default = `CSR_VOLT_3CELL_MV;
        2'h3:    csr_cell_default = `CSR_VOLT_4CELL_MV;
        default: csr_cell_default = `CSR_VOLT_1CELL_MV;
      endcase
    end
  endfunction

  // one word access aimed at one command code
  function csr_cmd_hit;
    input       stb;
    input [7:0] cmd;
    input [7:0] code;
    begin
      csr_cmd_hit = stb && (cmd == code);
    end
  endfunction

  assign wr_cur        = csr_cmd_hit(i_wr_stb, i_cmd, `CSR_CMD_CURRENT);
  assign wr_volt       = csr_cmd_hit(i_wr_stb, i_cmd, `CSR_CMD_VOLTAGE);
  assign wr_stat       = csr_cmd_hit(i_wr_stb, i_cmd, `CSR_CMD_STATUS);
  assign cur_bad       = |(i_wdata & `CSR_CUR_BAD_MASK); // RULE16
  assign volt_bad      = |(i_wdata & `CSR_VOLT_BAD_MASK); // RULE13
  assign volt_masked   = i_wdata & `CSR_VOLT_KEEP_MASK; // RULE12
  assign volt_zero     = (volt_masked == 16'h0000);
  assign volt_in_range = (volt_masked >= `CSR_VOLT_MIN_MV) && (volt_masked <= `CSR_VOLT_MAX_MV); // RULE6
  assign single_cell   = (i_cell_count_presence_pin == 2'h0);

  // hardware reasons to drop the current setpoint; converter faults are not among them
  assign cur_clear_evt = !i_battery_present || !i_input_present_flag ||
                         i_register_reset || i_watchdog_expired; // RULE17

  always @* begin
    cur_d  = o_charge_current_ma;
    volt_d = o_charge_voltage_mv;
    if (wr_cur && !cur_bad) begin
      cur_d = i_wdata & `CSR_CUR_KEEP_MASK; // RULE1 RULE2 RULE16 RULE18
    end
    if (wr_volt && !volt_bad) begin // RULE18
      if (volt_zero) begin
        cur_d = `CSR_CUR_RESET; // RULE11
      end else if (volt_in_range) begin
        volt_d = volt_masked; // RULE6 RULE12
      end else begin
        // out-of-range voltage keeps the stored setpoint
        volt_d = o_charge_voltage_mv; // RULE7
      end
    end
    if (i_register_reset) begin
      volt_d = csr_cell_default(i_cell_count_presence_pin);
    end
    if (cur_clear_evt) begin
      cur_d = `CSR_CUR_RESET; // RULE17
    end
  end

  always @* begin
    status_d[15] = i_input_present_flag; // RULE14
    status_d[14] = i_current_optimizer_complete;
    status_d[13] = i_peak_assist_active;
    status_d[12] = i_input_voltage_regulating;
    status_d[11] = i_input_current_regulating;
    status_d[10] = i_fast_charge_active;
    status_d[9]  = o_precharge_active;
    status_d[8]  = i_reverse_output_active;
    status_d[7]  = i_input_overvoltage_fault; // RULE15
    status_d[6]  = i_battery_overcurrent_fault;
    status_d[5]  = i_input_overcurrent_fault;
    status_d[2]  = i_converter_off_fault;
    status_d[1]  = i_reverse_output_overvoltage_fault;
    status_d[0]  = i_reverse_output_undervoltage_fault;
    // host-writable fault bits latch; a new fault wins over a host write
    status_d[`CSR_STAT_SYSOV_BIT] = status_q[`CSR_STAT_SYSOV_BIT];
    status_d[`CSR_STAT_SYSUV_BIT] = status_q[`CSR_STAT_SYSUV_BIT];
    if (wr_stat) begin
      status_d[`CSR_STAT_SYSOV_BIT] = i_wdata[`CSR_STAT_SYSOV_BIT]; // RULE15
      status_d[`CSR_STAT_SYSUV_BIT] = i_wdata[`CSR_STAT_SYSUV_BIT];
    end
    if (i_system_overvoltage_fault) begin
      status_d[`CSR_STAT_SYSOV_BIT] = 1'b1;
    end
    if (i_system_undervoltage_fault) begin
      status_d[`CSR_STAT_SYSUV_BIT] = 1'b1;
    end
  end

  // unmapped commands read as zero
  always @* begin
    case (i_cmd)
      `CSR_CMD_CURRENT: rdata_d = o_charge_current_ma;
      `CSR_CMD_VOLTAGE: rdata_d = o_charge_voltage_mv;
      `CSR_CMD_STATUS:  rdata_d = status_q;
      default:          rdata_d = 16'h0000;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_charge_current_ma <= `CSR_CUR_RESET;
      o_charge_voltage_mv <= csr_cell_default(i_cell_count_presence_pin); // RULE8
      status_q            <= `CSR_STAT_RESET; // RULE14
      o_charge_enable     <= 1'b0;
      o_rdata             <= 16'h0000;
      o_rd_valid          <= 1'b0;
    end else begin
      o_charge_current_ma <= cur_d;
      o_charge_voltage_mv <= volt_d;
      status_q            <= status_d;
      // charging runs once input power is good and a nonzero current is held
      o_charge_enable     <= i_input_power_good && (cur_d != 16'h0000); // RULE9
      o_rd_valid          <= i_rd_stb;
      if (i_rd_stb) begin
        o_rdata <= rdata_d;
      end
    end
  end

  csr_precharge_clamp u_clamp (
    .i_ref_clk                 (i_ref_clk),
    .i_rst                     (i_rst),
    .i_current_set_ma          (o_charge_current_ma),
    .i_single_cell             (single_cell),
    .i_linear_precharge_enable (i_linear_precharge_enable),
    .i_vbat_mv                 (i_vbat_mv),
    .i_vsys_min_mv             (i_vsys_min_mv),
    .o_current_target_ma       (o_current_target_ma),
    .o_precharge_active        (o_precharge_active),
    .o_battery_switch_linear   (o_battery_switch_linear),
    .o_sys_at_min              (o_sys_at_min)
  );

endmodule

// ---- bench/csr_charge_properties.sv ----
`timescale 1ns/1ps
module csr_charge_props (
  // bus and pins
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        i_wr_stb,
  input wire        i_rd_stb,
  input wire [7:0]  i_cmd,
  input wire [15:0] i_wdata,
  input wire        i_battery_present,
  input wire        i_input_power_good,
  input wire        i_register_reset,
  input wire        i_watchdog_expired,
  input wire        i_input_present_flag,
  // outputs
  input wire        o_rd_valid,
  input wire [15:0] o_charge_current_ma,
  input wire [15:0] o_charge_voltage_mv,
  input wire        o_charge_enable
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire        clr = !i_battery_present || !i_input_present_flag || i_register_reset || i_watchdog_expired;
  wire [15:0] vm  = i_wdata & 16'h7ff8;
  wire        wc  = i_wr_stb && i_cmd == 8'h14 && !clr;
  wire        wv  = i_wr_stb && i_cmd == 8'h15 && !i_wdata[15] && !clr;
  sequence s_ask;
    i_rd_stb ##1 o_rd_valid;
  endsequence
  AST_RD_ANSWER: assert property (i_rd_stb |-> s_ask) else $error("read not answered");
  AST_CUR_OK: assert property (wc && i_wdata[15:13] == 3'h0 |=>
    o_charge_current_ma == ($past(i_wdata) & 16'h1fc0)) else $error("current write lost");
  AST_CUR_BAD: assert property (wc && i_wdata[15:13] != 3'h0 |=>
    $stable(o_charge_current_ma)) else $error("invalid current write taken");
  AST_ENABLE: assert property (wc && i_wdata[15:13] == 3'h0 && i_wdata[12:6] != 7'h00 |=>
    o_charge_enable == $past(i_input_power_good)) else $error("charge enable wrong");
  AST_CLEAR: assert property (clr |=> o_charge_current_ma == 16'h0000) else $error("current not cleared");
  AST_VOLT_OK: assert property (wv && vm >= 16'h0400 && vm <= 16'h4b00 |=>
    o_charge_voltage_mv == $past(vm)) else $error("voltage write lost");
  AST_VOLT_RANGE: assert property (wv && vm != 16'h0000 && (vm < 16'h0400 || vm > 16'h4b00) |=>
    $stable(o_charge_voltage_mv)) else $error("out of range voltage taken");
  AST_VOLT_BAD: assert property (i_wr_stb && i_cmd == 8'h15 && i_wdata[15] && !i_register_reset |=>
    $stable(o_charge_voltage_mv)) else $error("invalid voltage write taken");
  AST_VOLT_ZERO: assert property (wv && vm == 16'h0000 |=>
    $stable(o_charge_voltage_mv) && o_charge_current_ma == 16'h0000) else $error("zero voltage wrong");
endmodule

bind csr_charge_regs csr_charge_props u_props (.i_ref_clk, .i_rst, .i_wr_stb, .i_rd_stb, .i_cmd, .i_wdata,
  .i_battery_present, .i_input_power_good, .i_register_reset, .i_watchdog_expired, .i_input_present_flag,
  .o_rd_valid, .o_charge_current_ma, .o_charge_voltage_mv, .o_charge_enable);

// ---- bench/csr_host_model.sv ----
`timescale 1ns/1ps
module csr_host_model (
  // answer
  input  wire        i_ref_clk,
  input  wire [15:0] i_rdata,
  input  wire        i_rd_valid,
  // request
  output reg         o_wr_stb = 1'b0,
  output reg         o_rd_stb = 1'b0,
  output reg  [7:0]  o_cmd    = 8'h00,
  output reg  [15:0] o_wdata  = 16'h0000
);
  // one-cycle strobe; the bus is scrambled once released
  task xfer(input w, input [7:0] c, input [15:0] d, output [15:0] q, output ok);
    integer k;
    begin
      @(posedge i_ref_clk) #1;
      o_wr_stb = w;
      o_rd_stb = !w;
      o_cmd    = c;
      o_wdata  = d;
      @(posedge i_ref_clk) #1;
      o_wr_stb = 1'b0;
      o_rd_stb = 1'b0;
      o_cmd    = ~c;
      o_wdata  = ~d;
      ok       = w;
      q        = 16'h0000;
      for (k = 0; k < 4 && !ok; k = k + 1) begin
        if (i_rd_valid === 1'b1) begin
          q  = i_rdata;
          ok = 1'b1;
        end else
          @(posedge i_ref_clk) #1;
      end
    end
  endtask
endmodule

// ---- bench/csr_charge_regs_tb.sv ----
`timescale 1ns/1ps
module csr_charge_regs_tb;
  logic        i_ref_clk, i_rst, i_wr_stb, i_rd_stb, o_rd_valid, o_charge_enable, pg, bp, rr, wd, ok, le, pa, bl, sm;
  logic [1:0]  cells;
  logic [7:0]  i_cmd;
  logic [15:0] i_wdata, o_rdata, o_charge_current_ma, o_charge_voltage_mv, tgt, vb, st, q;
  logic [15:0] vw [0:5] = '{16'h03f8, 16'h4b08, 16'h8400, 16'h4b07, 16'h0400, 16'h0000};
  logic [15:0] ve [0:5] = '{16'h3138, 16'h3138, 16'h3138, 16'h4b00, 16'h0400, 16'h0400};
  logic [17:0] cv [0:5] = '{18'h11388, 18'h11b58, 18'h00b54, 18'h00ce4, 18'h00e74, 18'h11388};
  logic [15:0] ce [0:5] = '{16'h0180, 16'h0c00, 16'h0180, 16'h07d0, 16'h0c00, 16'h0c00};
  logic [2:0]  cf [0:5] = '{3'h7, 3'h0, 3'h6, 3'h2, 3'h0, 3'h4};
  integer      bad_count, check_count, i;
  csr_host_model host (.i_ref_clk, .i_rdata(o_rdata), .i_rd_valid(o_rd_valid), .o_wr_stb(i_wr_stb),
    .o_rd_stb(i_rd_stb), .o_cmd(i_cmd), .o_wdata(i_wdata));
  csr_charge_regs uut (.i_ref_clk, .i_rst, .i_wr_stb, .i_rd_stb, .i_cmd, .i_wdata, .o_rdata, .o_rd_valid,
    .i_cell_count_presence_pin(cells), .i_battery_present(bp), .i_input_power_good(pg),
    .i_register_reset(rr), .i_watchdog_expired(wd), .i_linear_precharge_enable(le), .i_vbat_mv(vb),
    .i_vsys_min_mv(16'h1770), .i_input_present_flag(st[15]), .i_current_optimizer_complete(st[14]),
    .i_peak_assist_active(st[13]), .i_input_voltage_regulating(st[12]), .i_input_current_regulating(st[11]),
    .i_fast_charge_active(st[10]), .i_reverse_output_active(st[8]), .i_input_overvoltage_fault(st[7]),
    .i_battery_overcurrent_fault(st[6]), .i_input_overcurrent_fault(st[5]),
    .i_system_overvoltage_fault(st[4]), .i_system_undervoltage_fault(st[3]), .i_converter_off_fault(st[2]),
    .i_reverse_output_overvoltage_fault(st[1]), .i_reverse_output_undervoltage_fault(st[0]),
    .o_charge_current_ma, .o_charge_voltage_mv, .o_charge_enable, .o_current_target_ma(tgt),
    .o_precharge_active(pa), .o_battery_switch_linear(bl), .o_sys_at_min(sm));
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        $display("wrong value %s expected %h seen %h", n, e, g);
        bad_count = bad_count + 1;
      end
    end
  endtask
  task wr(input [7:0] c, input [15:0] d);
    host.xfer(1'b1, c, d, q, ok);
  endtask
  task rd(input [7:0] c, input [15:0] e);
    begin
      host.xfer(1'b0, c, 16'h0000, q, ok);
      if (!ok) begin
        bad_count = bad_count + 1;
        stop_test;
      end
      chk("read word", e, q);
    end
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    bad_count = 0;
    check_count = 0;
    {pg, bp, rr, wd} = 4'h4;
    le = 1'b1;
    {cells, vb, st} = {2'h0, 16'h4e20, 16'h0000};
    for (i = 0; i < 4; i = i + 1) begin
      cells = i[1:0];
      i_rst = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      rd(8'h15, (i[15:0] + 16'h0001) * 16'h1068);
      rd(8'h14, 16'h0000);
      rd(8'h20, 16'h0000);
    end
    st = 16'h8000;
    wr(8'h14, 16'h0100);
    chk("enable", 16'h0000, {15'h0000, o_charge_enable});
    pg = 1'b1;
    wr(8'h15, 16'h3138);
    wr(8'h14, 16'h1fff);
    rd(8'h14, 16'h1fc0);
    chk("enable", 16'h0001, {15'h0000, o_charge_enable});
    wr(8'h14, 16'h2080);
    rd(8'h14, 16'h1fc0);
    for (i = 0; i < 6; i = i + 1) begin
      wr(8'h15, vw[i]);
      rd(8'h15, ve[i]);
    end
    rd(8'h14, 16'h0000);
    st = 16'hfdff;
    rd(8'h20, 16'hfdff);
    st = 16'h8000;
    rd(8'h20, 16'h8018);
    wr(8'h20, 16'hffe7);
    rd(8'h20, 16'h8000);
    st = 16'h8010;
    wr(8'h20, 16'h0000);
    st = 16'h8000;
    rd(8'h20, 16'h8010);
    wr(8'h20, 16'h0000);
    rd(8'h20, 16'h8000);
    rd(8'h30, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h14, 16'h0c00);
      {bp, st[15], rr, wd} = 4'hc ^ (4'h8 >> i);
      @(posedge i_ref_clk) #1;
      {bp, st[15], rr, wd} = 4'hc;
      rd(8'h14, 16'h0000);
    end
    rd(8'h15, 16'h41a0);
    wr(8'h14, 16'h0c00);
    for (i = 0; i < 6; i = i + 1) begin
      {cells, vb} = cv[i];
      le = (i < 5);
      repeat (3) @(posedge i_ref_clk);
      #1 chk("target", ce[i], tgt);
      chk("clamp flags", {13'h0000, cf[i]}, {13'h0000, pa, bl, sm});
    end
    stop_test;
  end
endmodule
